// *** hw/pmfc_regs.vh ***
// Constants of the message field codec: field values, codings, unit selects
// Assumes inclusion by bare name from the codec design files
`ifndef PMFC_REGS_VH
`define PMFC_REGS_VH
`define PMFC_STATION_LOCAL   8'hFF
`define PMFC_SUB_BITREAD     8'h00
`define PMFC_ASC_ON          8'h31
`define PMFC_ASC_OFF         8'h30
`define PMFC_ASC_ZERO        8'h30
`define PMFC_ASC_A_MINUS10   8'h37
`define PMFC_ASC_LC_A        8'h61
`define PMFC_ASC_LC_F        8'h66
`define PMFC_ASC_UC_A        8'h41
`define PMFC_ASC_UC_F        8'h46
`define PMFC_ASC_NINE        8'h39
`define PMFC_CASE_SHIFT      8'h20
`define PMFC_UNIT_BIT        2'h0
`define PMFC_UNIT_BITWORD    2'h1
`define PMFC_UNIT_WORD       2'h2
`define PMFC_COMPLETE_OK     8'h00
`define PMFC_COMPLETE_MIN    8'h50
`define PMFC_COMPLETE_MAX    8'h60
`define PMFC_COMPLETE_DETAIL 8'h5B
`define PMFC_DETAIL_MIN      8'h10
`define PMFC_DETAIL_MAX      8'h18
`define PMFC_TIMER_STEP_MS   250
`define PMFC_CLK_MHZ         50
// One 250 ms step at 50 MHz, sized to the prescaler so nothing is cut
`define PMFC_STEP_CYCLES     24'd12500000
`define PMFC_STEP_W          24
`endif

// *** hw/pmfc_timer.v ***
// Monitoring timer: counts the wait for the controller in 250 ms steps
// Assumes start and done come from logic on mclk
`default_nettype none
`include "pmfc_regs.vh"
module pmfc_timer #(
  parameter [`PMFC_STEP_W-1:0] STEP_CYCLES = `PMFC_STEP_CYCLES
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        start,
  input  wire [15:0] steps,
  input  wire        done,
  output wire        busy,
  output wire        expired
);
  reg                    run_r;
  reg                    inf_r;
  reg [15:0]             left_r;
  reg [`PMFC_STEP_W-1:0] pre_r;
  reg                    exp_r;
  assign busy    = run_r;
  assign expired = exp_r;
  always @(posedge mclk) begin
    if (srst) begin
      run_r  <= 1'b0;
      inf_r  <= 1'b0;
      left_r <= 16'h0000;
      pre_r  <= {`PMFC_STEP_W{1'b0}};
      exp_r  <= 1'b0;
    end else begin
      exp_r <= 1'b0;
      if (start) begin
        run_r  <= 1'b1;
        inf_r  <= (steps == 16'h0000);
        left_r <= steps;
        pre_r  <= STEP_CYCLES - 1'b1;
      end else if (run_r) begin
        if (done) begin
          run_r <= 1'b0;
        end else if (!inf_r) begin
          if (pre_r != {`PMFC_STEP_W{1'b0}}) begin
            pre_r <= pre_r - 1'b1;
          end else if (left_r == 16'h0001) begin
            run_r <= 1'b0;
            exp_r <= 1'b1;
          end else begin
            left_r <= left_r - 16'h0001;
            pre_r  <= STEP_CYCLES - 1'b1;
          end
        end
      end
    end
  end
endmodule // pmfc_timer
`default_nettype wire

// *** hw/pmfc_codec.v ***
// Message field codec: character-area encode for responses, decode for commands
// Assumes all inputs come from logic on mclk; one symbol per handshake
// Operation
// - Target station field fixed at FFH
// - Bit-unit batch read subheader is 00H
// - Timer in 250 ms steps, low byte first
// - Read data in response, write data in command
// - Bit devices by point or 16-point word
// - ASCII bit point: 31H on, 30H off
// - ASCII bit word: four hex chars, MSB first
// - ASCII word device: hex chars, MSB first
// - Hex letters are upper case only
// - Non-integer word content returned raw
// - Binary bit point: one nibble, left first
// - Binary bit word: low byte, then high
// - Binary word device: low byte, then high
// - Binary LSB first, ASCII MSB first
// - Timer zero waits forever, else steps
// - Completion 00H ok, 50H-60H, 5BH detail
`default_nettype none
`include "pmfc_regs.vh"
module pmfc_codec #(
  parameter [`PMFC_STEP_W-1:0] STEP_CYCLES = `PMFC_STEP_CYCLES
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        ascii_mode,
  input  wire [1:0]  unit_sel,
  // Encode: device data to character-area symbols (response)
  input  wire        enc_valid,
  input  wire [15:0] enc_data,
  input  wire        enc_last,
  output wire        enc_ready,
  output wire        sym_valid,
  output wire [7:0]  sym_data,
  input  wire        sym_ready,
  // Decode: character-area symbols to device data (command)
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_last,
  output wire        rx_ready,
  output wire        dec_valid,
  output wire [15:0] dec_data,
  output wire        dec_err,
  // Header field checks and timer
  input  wire [7:0]  hdr_sub,
  input  wire [7:0]  hdr_station,
  input  wire [7:0]  hdr_timer_lo,
  input  wire [7:0]  hdr_timer_hi,
  output wire        hdr_station_ok,
  output wire        hdr_is_bitread,
  input  wire        req_start,
  input  wire        plc_done,
  input  wire [7:0]  plc_complete,
  input  wire [7:0]  plc_detail,
  output wire        wait_busy,
  output wire [7:0]  resp_complete,
  output wire [7:0]  resp_detail,
  output wire        resp_has_detail
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SEND = 2'h1;
  localparam [1:0] ST_LOAD = 2'h2;

  function [7:0] hex_chr;
    input [3:0] n;
    begin
      if (n < 4'hA) hex_chr = `PMFC_ASC_ZERO + {4'h0, n};
      else hex_chr = `PMFC_ASC_A_MINUS10 + {4'h0, n};
    end
  endfunction

  function [4:0] chr_hex; // bit 4 flags an illegal character
    input [7:0] c;
    begin
      if (c >= `PMFC_ASC_ZERO && c <= `PMFC_ASC_NINE) chr_hex = {1'b0, c[3:0]};
      else if (c >= `PMFC_ASC_UC_A && c <= `PMFC_ASC_UC_F) chr_hex = {1'b0, c[3:0] + 4'h9};
      else chr_hex = 5'h10;
    end
  endfunction

  wire tmo;
  pmfc_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
    .mclk    (mclk),
    .srst    (srst),
    .start   (req_start),
    .steps   ({hdr_timer_hi, hdr_timer_lo}),
    .done    (plc_done),
    .busy    (wait_busy),
    .expired (tmo)
  );

  assign hdr_station_ok = (hdr_station == `PMFC_STATION_LOCAL);
  assign hdr_is_bitread = (hdr_sub == `PMFC_SUB_BITREAD);

  reg [7:0] comp_r;
  reg [7:0] det_r;
  reg       hasdet_r;
  always @(posedge mclk) begin
    if (srst) begin
      comp_r   <= `PMFC_COMPLETE_OK;
      det_r    <= 8'h00;
      hasdet_r <= 1'b0;
    end else if (plc_done && wait_busy) begin
      if (plc_complete == `PMFC_COMPLETE_OK ||
          (plc_complete >= `PMFC_COMPLETE_MIN && plc_complete <= `PMFC_COMPLETE_MAX)) begin
        comp_r   <= plc_complete;
        hasdet_r <= (plc_complete == `PMFC_COMPLETE_DETAIL);
      end else begin
        // Unknown codes become 5BH, so a detail byte must follow as well
        comp_r   <= `PMFC_COMPLETE_DETAIL;
        hasdet_r <= 1'b1;
      end
      det_r    <= (plc_detail >= `PMFC_DETAIL_MIN && plc_detail <= `PMFC_DETAIL_MAX) ?
                  plc_detail : `PMFC_DETAIL_MIN;
    end else if (tmo) begin
      comp_r   <= `PMFC_COMPLETE_DETAIL;
      det_r    <= `PMFC_DETAIL_MIN;
      hasdet_r <= 1'b1;
    end
  end
  assign resp_complete   = comp_r;
  assign resp_detail     = det_r;
  assign resp_has_detail = hasdet_r;

  // Encoder: a loaded item becomes 1, 2 or 4 symbols, binary bit points two to a symbol; data never reinterpreted
  reg [1:0]  est_r;
  reg [15:0] ebuf_r;
  reg [1:0]  ecnt_r;
  reg [1:0]  eidx_r;
  reg        nib_hold_r;
  reg [3:0]  nib_r;
  reg [7:0]  eout_r;
  reg        epad_r;
  reg [1:0]  e_len;
  reg [7:0]  e_sym;
  always @* begin
    e_len = 2'h0;
    e_sym = 8'h00;
    case (unit_sel)
      `PMFC_UNIT_BIT: begin
        e_len = 2'h0;
        if (ascii_mode) e_sym = ebuf_r[0] ? `PMFC_ASC_ON : `PMFC_ASC_OFF;
        else e_sym = {nib_r, 3'h0, ebuf_r[0]};
      end
      default: begin
        if (ascii_mode) begin
          e_len = 2'h3;
          e_sym = hex_chr(ebuf_r[15 - {eidx_r, 2'h0} -: 4]);
        end else begin
          e_len = 2'h1;
          e_sym = eidx_r[0] ? ebuf_r[15:8] : ebuf_r[7:0];
        end
      end
    endcase
  end
  wire bin_pt = !ascii_mode && (unit_sel == `PMFC_UNIT_BIT);
  assign enc_ready = (est_r == ST_IDLE) && !epad_r;
  assign sym_valid = (est_r == ST_SEND);
  assign sym_data  = eout_r;
  always @(posedge mclk) begin
    if (srst) begin
      est_r      <= ST_IDLE;
      ebuf_r     <= 16'h0000;
      ecnt_r     <= 2'h0;
      eidx_r     <= 2'h0;
      nib_hold_r <= 1'b0;
      nib_r      <= 4'h0;
      eout_r     <= 8'h00;
      epad_r     <= 1'b0;
    end else begin
      case (est_r)
        ST_IDLE: begin
          if (epad_r) begin
            eout_r <= {nib_r, 4'h0};
            ecnt_r <= 2'h0;
            epad_r <= 1'b0;
            nib_hold_r <= 1'b0;
            est_r  <= ST_SEND;
          end else if (enc_valid) begin
            ebuf_r <= enc_data;
            eidx_r <= 2'h0;
            if (bin_pt && !nib_hold_r) begin
              nib_r      <= {3'h0, enc_data[0]};
              nib_hold_r <= 1'b1;
              epad_r     <= enc_last;
            end else begin
              // Symbol count is loaded once per item, not per symbol
              nib_hold_r <= 1'b0;
              ecnt_r     <= e_len;
              est_r      <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          eout_r <= e_sym;
          est_r  <= ST_SEND;
        end
        ST_SEND: begin
          if (sym_ready) begin
            if (ecnt_r == 2'h0) begin
              est_r <= ST_IDLE;
            end else begin
              ecnt_r <= ecnt_r - 2'h1;
              eidx_r <= eidx_r + 2'h1;
              est_r  <= ST_LOAD;
            end
          end
        end
        default: est_r <= ST_IDLE;
      endcase
    end
  end

  // Decoder: gathers symbols into one item per point or word
  reg [15:0] dacc_r;
  reg [1:0]  dcnt_r;
  reg [15:0] dout_r;
  reg        dval_r;
  reg        derr_r;
  reg [4:0]  dh;
  reg [15:0] dacc_nxt;
  reg [1:0]  dcnt_nxt;
  reg        dfin;
  reg        derr_nxt;
  reg        dpair;
  always @* begin
    dh       = chr_hex(rx_data);
    dacc_nxt = dacc_r;
    dcnt_nxt = dcnt_r + 2'h1;
    dfin     = 1'b0;
    derr_nxt = 1'b0;
    dpair    = 1'b0;
    if (unit_sel == `PMFC_UNIT_BIT) begin
      dcnt_nxt = 2'h0;
      dfin     = 1'b1;
      if (ascii_mode) begin
        dacc_nxt = {15'h0000, rx_data == `PMFC_ASC_ON};
        derr_nxt = (rx_data != `PMFC_ASC_ON) && (rx_data != `PMFC_ASC_OFF);
      end else begin
        dacc_nxt = {15'h0000, rx_data[4]};
        dpair    = !rx_last;
      end
    end else if (ascii_mode) begin
      dacc_nxt = {dacc_r[11:0], dh[3:0]};
      derr_nxt = dh[4];
      dfin     = (dcnt_r == 2'h3);
    end else begin
      dacc_nxt = dcnt_r[0] ? {rx_data, dacc_r[7:0]} : {8'h00, rx_data};
      dfin     = dcnt_r[0];
    end
    if (dfin) dcnt_nxt = 2'h0;
  end
  reg       dsec_r;
  reg [7:0] dbyte_r;
  assign rx_ready  = !dsec_r;
  assign dec_valid = dval_r;
  assign dec_data  = dout_r;
  assign dec_err   = derr_r;
  always @(posedge mclk) begin
    if (srst) begin
      dacc_r  <= 16'h0000;
      dcnt_r  <= 2'h0;
      dout_r  <= 16'h0000;
      dval_r  <= 1'b0;
      derr_r  <= 1'b0;
      dsec_r  <= 1'b0;
      dbyte_r <= 8'h00;
    end else begin
      dval_r <= 1'b0;
      derr_r <= 1'b0;
      if (dsec_r) begin
        dout_r <= {15'h0000, dbyte_r[0]};
        dval_r <= 1'b1;
        dsec_r <= 1'b0;
      end else if (rx_valid) begin
        dacc_r <= dacc_nxt;
        dcnt_r <= dcnt_nxt;
        derr_r <= derr_nxt;
        if (dfin) begin
          dout_r <= dacc_nxt;
          dval_r <= 1'b1;
        end
        if (dpair) begin
          dsec_r  <= 1'b1;
          dbyte_r <= rx_data;
        end
      end
    end
  end
endmodule // pmfc_codec
`default_nettype wire

// *** tb/pmfc_codec_properties.sv ***
// Port checker for the message field codec
// Assumes one mclk domain with srst synchronous, active high
`default_nettype none
module pmfc_codec_properties #(
  parameter [23:0] STEP_CYCLES = 24'h4
) (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        ascii_mode,
  input wire logic [1:0]  unit_sel,
  input wire logic        enc_valid,
  input wire logic        enc_ready,
  input wire logic        sym_valid,
  input wire logic [7:0]  sym_data,
  input wire logic        sym_ready,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_ready,
  input wire logic        dec_valid,
  input wire logic [15:0] dec_data,
  input wire logic [7:0]  hdr_sub,
  input wire logic [7:0]  hdr_station,
  input wire logic [7:0]  hdr_timer_lo,
  input wire logic [7:0]  hdr_timer_hi,
  input wire logic        hdr_station_ok,
  input wire logic        hdr_is_bitread,
  input wire logic        req_start,
  input wire logic        plc_done,
  input wire logic        wait_busy,
  input wire logic [7:0]  resp_complete,
  input wire logic [7:0]  resp_detail,
  input wire logic        resp_has_detail
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_take; enc_valid && enc_ready && ascii_mode; endsequence
  sequence s_stall; sym_valid && !sym_ready; endsequence
  sequence s_zero_wait; req_start && {hdr_timer_hi, hdr_timer_lo} == 16'h0 ##1 !plc_done [*8]; endsequence
  AST_STATION: assert property (hdr_station_ok == (hdr_station == 8'hFF))
    else $error("station flag wrong");
  AST_BITREAD: assert property (hdr_is_bitread == (hdr_sub == 8'h00))
    else $error("bit read flag wrong");
  AST_ENC_LAT: assert property (s_take |-> ##2 sym_valid)
    else $error("symbol late");
  AST_HOLD: assert property (s_stall |=> sym_valid && $stable(sym_data))
    else $error("symbol dropped while stalled");
  AST_REFUSE: assert property (sym_valid |-> !enc_ready)
    else $error("item taken while sending");
  AST_ASC_PT: assert property (sym_valid && ascii_mode && unit_sel == 2'h0 |-> sym_data inside {8'h30, 8'h31})
    else $error("bad point char");
  AST_ASC_HEX: assert property (sym_valid && ascii_mode && unit_sel != 2'h0 |->
    sym_data inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("bad hex char");
  AST_DEC_PT: assert property (rx_valid && rx_ready && ascii_mode && unit_sel == 2'h0 && rx_data inside {8'h30, 8'h31}
    |=> dec_valid && dec_data[0] == $past(rx_data[0]))
    else $error("point not decoded");
  AST_WAIT: assert property (req_start |=> wait_busy)
    else $error("wait not started");
  AST_FOREVER: assert property (s_zero_wait |-> wait_busy)
    else $error("zero timer expired");
  AST_CODE: assert property (resp_complete == 8'h00 || resp_complete inside {[8'h50:8'h60]})
    else $error("completion out of range");
  AST_DETAIL: assert property (resp_has_detail |-> resp_complete == 8'h5B && resp_detail inside {[8'h10:8'h18]})
    else $error("detail wrong");
  AST_DETAIL_FOLLOWS: assert property (resp_complete == 8'h5B |-> resp_has_detail)
    else $error("detail missing after 5B");
endmodule // pmfc_codec_properties
bind pmfc_codec pmfc_codec_properties #(.STEP_CYCLES(STEP_CYCLES)) chk_i (.mclk, .srst, .ascii_mode, .unit_sel,
  .enc_valid, .enc_ready, .sym_valid, .sym_data, .sym_ready, .rx_valid, .rx_data, .rx_ready, .dec_valid, .dec_data,
  .hdr_sub, .hdr_station, .hdr_timer_lo, .hdr_timer_hi, .hdr_station_ok, .hdr_is_bitread, .req_start, .plc_done,
  .wait_busy, .resp_complete, .resp_detail, .resp_has_detail);
`default_nettype wire

// *** tb/pmfc_host.sv ***
// Far-side host model: takes response symbols
// Assumes the codec symbol handshake on mclk
`default_nettype none
module pmfc_host (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       slow,
  input  wire logic       sym_valid,
  input  wire logic [7:0] sym_data,
  output var  logic       sym_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  integer     seed = 72;
  // A slow host drops ready at random so held symbols get exercised
  always @(posedge mclk) begin
    if (srst)
      sym_ready <= 1'b0;
    else
      sym_ready <= slow ? 1'($random(seed)) : 1'b1;
    if (srst !== 1'b1 && sym_valid === 1'b1 && sym_ready === 1'b1)
      got.push_back(sym_data);
  end
endmodule // pmfc_host
`default_nettype wire

// *** tb/test_plc_message_field_codec.sv ***
// Self-checking bench for the message field codec
// Assumes pmfc_host on the symbol side and the bound checker
`default_nettype none
module test_plc_message_field_codec;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, srst, ascii_mode, enc_valid, enc_last, enc_ready, sym_valid, sym_ready, slow;
  logic        rx_valid, rx_last, rx_ready, dec_valid, dec_err, hdr_station_ok, hdr_is_bitread;
  logic        req_start, plc_done, wait_busy, resp_has_detail;
  logic [1:0]  unit_sel;
  logic [7:0]  sym_data, rx_data, hdr_sub, hdr_station, hdr_timer_lo, hdr_timer_hi;
  logic [7:0]  plc_complete, plc_detail, resp_complete, resp_detail;
  logic [15:0] enc_data, dec_data;
  logic [15:0] dq[$];
  logic [15:0] exd[7] = '{16'h0A3F, 16'h1234, 16'h1, 16'h0, 16'h1, 16'h1, 16'h0};
  integer      seed = 72;
  int          miscompares = 0, total_checks = 0, errs = 0;
  pmfc_codec #(.STEP_CYCLES(24'h4)) uut (.mclk, .srst, .ascii_mode, .unit_sel, .enc_valid, .enc_data, .enc_last,
    .enc_ready, .sym_valid, .sym_data, .sym_ready, .rx_valid, .rx_data, .rx_last, .rx_ready, .dec_valid, .dec_data,
    .dec_err, .hdr_sub, .hdr_station, .hdr_timer_lo, .hdr_timer_hi, .hdr_station_ok, .hdr_is_bitread, .req_start,
    .plc_done, .plc_complete, .plc_detail, .wait_busy, .resp_complete, .resp_detail, .resp_has_detail);
  pmfc_host host (.mclk, .srst, .slow, .sym_valid, .sym_data, .sym_ready);
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (dec_valid === 1'b1)
      dq.push_back(dec_data);
    if (dec_err === 1'b1)
      errs++;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return n < 4'hA ? 8'h30 + n : 8'h37 + n;
  endfunction
  function automatic void exp_syms(input logic a, input logic [1:0] u, input logic [15:0] it[$], ref logic [7:0] ex[$]);
    foreach (it[i]) begin
      if (a && u == 2'h0)
        ex.push_back(it[i][0] ? 8'h31 : 8'h30);
      else if (a)
        for (int s = 12; s >= 0; s -= 4) ex.push_back(hexc(it[i][s+:4]));
      else if (u != 2'h0) begin
        ex.push_back(it[i][7:0]);
        ex.push_back(it[i][15:8]);
      end else if (i % 2)
        ex[ex.size()-1] = ex[ex.size()-1] | {7'h0, it[i][0]};
      else
        ex.push_back({3'h0, it[i][0], 4'h0});
    end
  endfunction
  task automatic enc_run(input logic a, input logic [1:0] u, input int n);
    logic [15:0] it[$];
    logic [7:0]  ex[$];
    int          w;
    ascii_mode <= a;
    unit_sel <= u;
    slow <= u == 2'h1;
    host.got.delete();
    for (int i = 0; i < n; i++) begin
      it.push_back(u == 2'h0 ? 16'($random(seed) & 1) : 16'($random(seed)));
      w = 0;
      enc_valid <= 1'b1;
      enc_data <= it[i];
      enc_last <= i == n - 1;
      do @(posedge mclk); while (enc_ready !== 1'b1 && ++w < 200);
      if (w >= 200) miscompares++;
    end
    enc_valid <= 1'b0;
    exp_syms(a, u, it, ex);
    w = 0;
    while (host.got.size() < ex.size() && w++ < 500) @(posedge mclk);
    chk(16'(host.got.size()), 16'(ex.size()));
    foreach (ex[i]) chk(host.got[i], ex[i]);
  endtask
  task automatic rx_run(input logic a, input logic [1:0] u, input logic [31:0] s, input int n);
    int w;
    ascii_mode <= a;
    unit_sel <= u;
    @(posedge mclk);
    for (int k = 0; k < n; k++) begin
      w = 0;
      rx_valid <= 1'b1;
      rx_data <= s[31-8*k -: 8];
      rx_last <= k == n - 1;
      do @(posedge mclk); while (rx_ready !== 1'b1 && ++w < 50);
      if (w >= 50) miscompares++;
    end
    rx_valid <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic tmr(input logic [15:0] t, input logic [7:0] c, input logic [7:0] d);
    int         n;
    logic [7:0] e;
    n = 0;
    hdr_timer_lo <= t[7:0];
    hdr_timer_hi <= t[15:8];
    req_start <= 1'b1;
    @(posedge mclk);
    req_start <= 1'b0;
    plc_complete <= c;
    plc_detail <= d;
    @(posedge mclk);
    while (wait_busy === 1'b1 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    if (t == 16'h0) begin
      chk(16'(n), 16'd60);
      plc_done <= 1'b1;
      @(posedge mclk);
      plc_done <= 1'b0;
    end else
      chk(n >= 4 * t && n <= 4 * t + 3, 1'b1);
    repeat (2) @(posedge mclk);
    e = t != 16'h0 ? 8'h5B : (c == 8'h00 || (c >= 8'h50 && c <= 8'h60)) ? c : 8'h5B;
    chk(resp_complete, e);
    chk(resp_has_detail, e == 8'h5B);
    if (e == 8'h5B)
      chk(resp_detail, t == 16'h0 && d >= 8'h10 && d <= 8'h18 ? d : 8'h10);
  endtask
  task final_report;
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {mclk, ascii_mode, unit_sel, enc_valid, enc_data, enc_last, rx_valid, rx_data, rx_last, slow} = '0;
    {hdr_sub, hdr_station, hdr_timer_lo, hdr_timer_hi, req_start, plc_done, plc_complete, plc_detail} = '0;
    srst = 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      hdr_station <= i[0] ? 8'hFF : 8'($random(seed));
      hdr_sub <= i[1] ? 8'h00 : 8'($random(seed));
      @(negedge mclk);
      chk(hdr_station_ok, hdr_station == 8'hFF);
      chk(hdr_is_bitread, hdr_sub == 8'h00);
      @(posedge mclk);
    end
    for (int a = 0; a < 2; a++)
      for (int u = 0; u < 3; u++)
        enc_run(a[0], u[1:0], 3 + u);
    rx_run(1'b1, 2'h2, "0A3F", 4);
    rx_run(1'b0, 2'h2, 32'h3412_0000, 2);
    rx_run(1'b0, 2'h0, 32'h1010_0000, 2);
    rx_run(1'b1, 2'h0, {"10", 16'h0}, 2);
    chk(16'(dq.size()), 16'd7);
    foreach (exd[i]) chk(dq[i], exd[i]);
    chk(16'(errs), 16'd0);
    rx_run(1'b1, 2'h2, "0a3F", 4);
    chk(errs != 0, 1'b1);
    tmr(16'h000A, 8'h00, 8'h00);
    tmr(16'h0000, 8'h00, 8'h00);
    tmr(16'h0000, 8'h5B, 8'h12);
    tmr(16'h0000, 8'h7F, 8'h00);
    tmr(16'h0000, 8'h55, 8'h00);
    final_report();
  end
  // Run needs well under a thousand cycles; this only cuts a hang
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    final_report();
  end
endmodule // test_plc_message_field_codec
`default_nettype wire
